// ---- core/spg_ctrl.sv ----
/*
 sleep entry gating, brown-out sleep disable timed sequence, peripheral clock
 gating and reset merging with a stretch counter, with apb registers.
 assumes reset source inputs are synchronous to REF_CLK except the merged
 asynchronous port reset path, which is pure combinational logic.
*/
`timescale 1ns/1ps

// What this block does
// - sleep only when sleep enable is set
// - disable bit set only by unlock sequence
// - disable active one cycle after a three-cycle settle; sleep then drops detector
// - disable bit clears itself after four cycles
// - bit 7 stops two-wire clock
// - bit 6 freezes timer two in sync mode
// - bits 5,3 freeze timers zero and one
// - bit 4 reads as zero
// - bit 2 stops serial peripheral clock
// - bit 1 stops usart clock
// - bit 0 stops converter clock, converter itself stays on
// - reset loads registers, fetch from reset vector
// - ports reset asynchronously on any source
// - internal reset stretched by delay counter
// - four reset sources merged
// - external pin resets unless disabled
// - power-on reasserts immediately, releases through counter
// - brown-out asserts immediately, releases through counter
// - watchdog reset pulse is one cycle
// - modes 110 and 111 need crystal clock
// - watchdog flag set by watchdog, cleared by write
module spg_ctrl #(
	parameter logic [15:0] DELAY_CYCLES = spg_pkg::DELAY_DEFAULT
)(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SLEEP_INSTR,
	input wire logic CRYSTAL_CLOCK_SEL,
	input wire logic TIMER_TWO_ASYNC_SELECT,
	input wire logic RESET_PIN_DISABLE_SETTING,
	input wire logic BROWNOUT_ENABLED,
	input wire spg_pkg::spg_rst_src_s RESET_SOURCES,
	input wire spg_pkg::spg_clk_en_s PERIPH_ACCESS,
	output logic SLEEP_ENTER,
	output logic [2:0] SLEEP_MODE,
	output logic BROWNOUT_SLEEP_OFF,
	output logic GLOBAL_PULLUP_DISABLE,
	output logic VECTOR_TABLE_SELECT,
	output spg_pkg::spg_clk_en_s CLK_EN,
	output spg_pkg::spg_clk_en_s PERIPH_ACCESS_OK,
	output logic PORT_RESET,
	output logic INTERNAL_RESET,
	output logic FETCH_START
);
	import spg_pkg::*;

	logic [7:0] mcu_control_reg, mcu_control_next;
	logic [7:0] power_reduction_reg, power_reduction_next;
	logic [3:0] sleep_control_reg, sleep_control_next;
	logic [3:0] reset_status_reg, reset_status_next;
	logic [15:0] delay_config_reg, delay_config_next;
	logic [2:0] unlock_cnt_reg, unlock_cnt_next;
	logic [2:0] sdis_cnt_reg, sdis_cnt_next;
	logic [2:0] vec_cnt_reg, vec_cnt_next;
	logic [15:0] stretch_cnt_reg, stretch_cnt_next;
	logic int_rst_reg, int_rst_next;
	logic fetch_reg, fetch_next;
	logic sleep_reg, sleep_next;
	logic bod_off_reg, bod_off_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pin_reset, wdog_reset, brown_reset, any_source;
	logic wr_en, rd_en;
	logic [7:0] wbyte;
	logic sdis_active;

	// apb strobes; single-cycle access phase, no wait states
	// reads capture in setup so PRDATA is already a flop in the access phase
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	assign wbyte = PWDATA[7:0];
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = prdata_reg;

	// four sources, pin and brown-out qualified
	// pin function drops out when the setting disables it
	// limitation: no pulse-width filter here, the input level is taken as qualified
	assign pin_reset = RESET_SOURCES.ext_pin_low && !RESET_PIN_DISABLE_SETTING;
	assign brown_reset = RESET_SOURCES.brownout && BROWNOUT_ENABLED;
	// watchdog source arrives as a one-cycle pulse
	assign wdog_reset = RESET_SOURCES.watchdog;
	assign any_source = RESET_SOURCES.power_on || pin_reset || wdog_reset || brown_reset;
	// port reset is combinational, needs no clock
	assign PORT_RESET = any_source || RST;

	// disable bit counts as active once its three-cycle settle has run
	// the settle counter runs while the bit is visible; zero marks the usable cycle
	// active only after the settle count
	assign sdis_active = mcu_control_reg[BIT_SDIS] && (sdis_cnt_reg == 3'h0);

	// control register next state
	always_comb
	begin
		mcu_control_next = mcu_control_reg;
		power_reduction_next = power_reduction_reg;
		sleep_control_next = sleep_control_reg;
		delay_config_next = delay_config_reg;
		unlock_cnt_next = (unlock_cnt_reg != 3'h0) ? unlock_cnt_reg - 3'h1 : 3'h0;
		vec_cnt_next = (vec_cnt_reg != 3'h0) ? vec_cnt_reg - 3'h1 : 3'h0;
		sdis_cnt_next = sdis_cnt_reg;
		// self clear after the three-cycle settle and one active cycle
		if (mcu_control_reg[BIT_SDIS])
		begin
			if (sdis_cnt_reg != 3'h0)
				sdis_cnt_next = sdis_cnt_reg - 3'h1;
			else
				mcu_control_next[BIT_SDIS] = 1'b0;
		end
		if (vec_cnt_reg == 3'h0)
			mcu_control_next[BIT_VEC_UNLOCK] = 1'b0;
		if (unlock_cnt_reg == 3'h0)
			mcu_control_next[BIT_SDIS_UNLOCK] = 1'b0;
		if (wr_en && PADDR == MCU_CONTROL_ADDR)
		begin
			mcu_control_next[BIT_PULLUP_OFF] = wbyte[BIT_PULLUP_OFF];
			// a repeated first step restarts the window instead of setting the bit
			// first step, both bits one opens window
			if (wbyte[BIT_SDIS] && wbyte[BIT_SDIS_UNLOCK])
			begin
				mcu_control_next[BIT_SDIS_UNLOCK] = 1'b1;
				unlock_cnt_next = UNLOCK_WINDOW_CYC;
			end
			// second step inside window sets the bit
			else if (wbyte[BIT_SDIS] && unlock_cnt_reg != 3'h0)
			begin
				mcu_control_next[BIT_SDIS] = 1'b1;
				mcu_control_next[BIT_SDIS_UNLOCK] = 1'b0;
				sdis_cnt_next = SDIS_LIFE_CYC;
				unlock_cnt_next = 3'h0;
			end
			// outside window the disable bit holds
			else
			begin
				mcu_control_next[BIT_SDIS_UNLOCK] = 1'b0;
			end
			// vector select uses the same unlock-then-write style
			if (wbyte[BIT_VEC_UNLOCK])
			begin
				mcu_control_next[BIT_VEC_UNLOCK] = 1'b1;
				vec_cnt_next = UNLOCK_WINDOW_CYC;
			end
			else if (vec_cnt_reg != 3'h0)
			begin
				mcu_control_next[BIT_VEC_SEL] = wbyte[BIT_VEC_SEL];
				mcu_control_next[BIT_VEC_UNLOCK] = 1'b0;
				vec_cnt_next = 3'h0;
			end
		end
		// reserved bit 4 masked, never stored
		if (wr_en && PADDR == POWER_REDUCTION_ADDR)
			power_reduction_next = wbyte & POWER_REDUCTION_WMASK;
		if (wr_en && PADDR == SLEEP_CONTROL_ADDR)
			sleep_control_next = wbyte[3:0];
		if (wr_en && PADDR == DELAY_CONFIG_ADDR)
			delay_config_next = PWDATA[15:0];
	end

	// all registers take initial values while reset holds
	always_ff @(posedge REF_CLK)
	begin
		if (RST || int_rst_reg)
		begin
			mcu_control_reg <= MCU_CONTROL_RESET;
			power_reduction_reg <= POWER_REDUCTION_RESET;
			sleep_control_reg <= 4'h0;
			unlock_cnt_reg <= 3'h0;
			sdis_cnt_reg <= 3'h0;
			vec_cnt_reg <= 3'h0;
		end
		else
		begin
			mcu_control_reg <= mcu_control_next;
			power_reduction_reg <= power_reduction_next;
			sleep_control_reg <= sleep_control_next;
			unlock_cnt_reg <= unlock_cnt_next;
			sdis_cnt_reg <= sdis_cnt_next;
			vec_cnt_reg <= vec_cnt_next;
		end
	end

	// delay setting survives internal reset, like a fuse
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			delay_config_reg <= DELAY_DEFAULT;
		else
			delay_config_reg <= delay_config_next;
	end

	// sleep entry and brown-out off decision
	always_comb
	begin
		sleep_next = 1'b0;
		// detector stays off for the whole sleep, not only the entry cycle,
		// since the disable bit clears itself while the core still sleeps
		bod_off_next = 1'b0;
		// sleep instruction only acts with enable set
		// standby modes refused without crystal clock
		if (SLEEP_INSTR && sleep_control_reg[BIT_SLEEP_EN] && !int_rst_reg)
		begin
			if (sleep_control_reg[3:1] == MODE_STANDBY || sleep_control_reg[3:1] == MODE_EXT_STANDBY)
				sleep_next = CRYSTAL_CLOCK_SEL;
			else
				sleep_next = 1'b1;
			// detector off only if bit active at sleep
			bod_off_next = sleep_next && (sdis_active || (bod_off_reg && sleep_reg));
		end
		else if (sleep_reg && sleep_control_reg[BIT_SLEEP_EN] && SLEEP_INSTR)
		begin
			sleep_next = 1'b1;
			bod_off_next = bod_off_reg;
		end
	end

	// sleep state registers
	always_ff @(posedge REF_CLK)
	begin
		if (RST || int_rst_reg)
		begin
			sleep_reg <= 1'b0;
			bod_off_reg <= 1'b0;
		end
		else
		begin
			sleep_reg <= sleep_next;
			bod_off_reg <= bod_off_next;
		end
	end

	// reset stretch: any source reloads, count runs after all release
	always_comb
	begin
		stretch_cnt_next = stretch_cnt_reg;
		int_rst_next = int_rst_reg;
		fetch_next = 1'b0;
		// power-on and brown-out reassert with no delay
		// release waits on the stretch counter
		if (any_source)
		begin
			stretch_cnt_next = delay_config_reg;
			int_rst_next = 1'b1;
		end
		// a source still high keeps reloading, so counting starts at the last release
		// count down after every source is gone
		else if (stretch_cnt_reg != 16'h0)
		begin
			stretch_cnt_next = stretch_cnt_reg - 16'h1;
		end
		else if (int_rst_reg)
		begin
			int_rst_next = 1'b0;
			// one-cycle pulse to start fetch at vector
			fetch_next = 1'b1;
		end
	end

	// stretch registers
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			stretch_cnt_reg <= DELAY_CYCLES;
			int_rst_reg <= 1'b1;
			fetch_reg <= 1'b0;
		end
		else
		begin
			stretch_cnt_reg <= stretch_cnt_next;
			int_rst_reg <= int_rst_next;
			fetch_reg <= fetch_next;
		end
	end

	// reset cause flags; set wins over a software clear
	// a clear meeting a new event loses; a power-on event overwrites the other flags with its own
	always_comb
	begin
		reset_status_next = reset_status_reg;
		if (wr_en && PADDR == RESET_STATUS_ADDR)
			reset_status_next = reset_status_reg & wbyte[3:0];
		if (wdog_reset)
			reset_status_next[BIT_WDOG_FLAG] = 1'b1;
		if (brown_reset)
			reset_status_next[BIT_BROWN_FLAG] = 1'b1;
		if (pin_reset)
			reset_status_next[BIT_EXT_FLAG] = 1'b1;
		if (RESET_SOURCES.power_on)
			reset_status_next = 4'h1;
	end

	// flags survive internal reset
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			reset_status_reg <= 4'h1;
		else
			reset_status_reg <= reset_status_next;
	end

	// read mux, registered in setup phase
	always_comb
	begin
		prdata_next = prdata_reg;
		if (rd_en)
		begin
			case (PADDR)
				MCU_CONTROL_ADDR: prdata_next = {24'h0, mcu_control_reg & MCU_CONTROL_WMASK};
				// bit 4 always zero on read
				POWER_REDUCTION_ADDR: prdata_next = {24'h0, power_reduction_reg & POWER_REDUCTION_WMASK};
				SLEEP_CONTROL_ADDR: prdata_next = {28'h0, sleep_control_reg};
				RESET_STATUS_ADDR: prdata_next = {28'h0, reset_status_reg};
				DELAY_CONFIG_ADDR: prdata_next = {16'h0, delay_config_reg};
				// unmapped offsets read zero and raise no error
				default: prdata_next = APB_ERR_NONE;
			endcase
		end
	end

	// read data register
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			prdata_reg <= 32'h0;
		else
			prdata_reg <= prdata_next;
	end

	// clock gates; a stopped clock freezes state, so resume is exact
	// two-wire clock gate
	assign CLK_EN.two_wire_interface = !power_reduction_reg[BIT_GATE_TWI];
	// timer two frozen only in synchronous mode
	assign CLK_EN.timer_two = !(power_reduction_reg[BIT_GATE_T2] && !TIMER_TWO_ASYNC_SELECT);
	// timers zero and one freeze and resume
	assign CLK_EN.timer_zero = !power_reduction_reg[BIT_GATE_T0];
	assign CLK_EN.timer_one = !power_reduction_reg[BIT_GATE_T1];
	assign CLK_EN.spi = !power_reduction_reg[BIT_GATE_SPI];
	assign CLK_EN.usart = !power_reduction_reg[BIT_GATE_USART];
	// limitation: gating does not disable the converter, software must do that first
	// converter clock gate
	assign CLK_EN.adc = !power_reduction_reg[BIT_GATE_ADC];
	assign PERIPH_ACCESS_OK = PERIPH_ACCESS & CLK_EN;

	assign SLEEP_ENTER = sleep_reg;
	assign SLEEP_MODE = sleep_control_reg[3:1];
	assign BROWNOUT_SLEEP_OFF = bod_off_reg;
	assign GLOBAL_PULLUP_DISABLE = mcu_control_reg[BIT_PULLUP_OFF];
	assign VECTOR_TABLE_SELECT = mcu_control_reg[BIT_VEC_SEL];
	assign INTERNAL_RESET = int_rst_reg;
	assign FETCH_START = fetch_reg;
endmodule

// ---- common/spg_pkg.sv ----
/*
 package for the sleep, power-gate and reset control block: register offsets,
 field positions, reset values, timing counts and carrier structs.
 assumes a 32-bit apb bus with byte addresses.
*/
package spg_pkg;
	// register byte offsets on apb (printed offsets not multiples of four -> index * 4)
	localparam logic [7:0] MCU_CONTROL_IDX = 8'h35;
	localparam logic [11:0] MCU_CONTROL_ADDR = 12'h0d4;
	localparam logic [11:0] POWER_REDUCTION_ADDR = 12'h100;
	localparam logic [11:0] SLEEP_CONTROL_ADDR = 12'h104;
	localparam logic [11:0] RESET_STATUS_ADDR = 12'h108;
	localparam logic [11:0] DELAY_CONFIG_ADDR = 12'h10c;
	// mcu_control fields
	localparam int BIT_SDIS = 6;
	localparam int BIT_SDIS_UNLOCK = 5;
	localparam int BIT_PULLUP_OFF = 4;
	localparam int BIT_VEC_SEL = 1;
	localparam int BIT_VEC_UNLOCK = 0;
	localparam logic [7:0] MCU_CONTROL_WMASK = 8'h73;
	localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
	// power_reduction fields
	localparam int BIT_GATE_TWI = 7;
	localparam int BIT_GATE_T2 = 6;
	localparam int BIT_GATE_T0 = 5;
	localparam int BIT_GATE_T1 = 3;
	localparam int BIT_GATE_SPI = 2;
	localparam int BIT_GATE_USART = 1;
	localparam int BIT_GATE_ADC = 0;
	localparam logic [7:0] POWER_REDUCTION_WMASK = 8'hef;
	localparam logic [7:0] POWER_REDUCTION_RESET = 8'h00;
	// sleep control fields
	localparam int BIT_SLEEP_EN = 0;
	localparam int SLEEP_MODE_LSB = 1;
	localparam logic [7:0] SLEEP_CONTROL_WMASK = 8'h0f;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;
	// reset status fields
	localparam int BIT_WDOG_FLAG = 3;
	localparam int BIT_BROWN_FLAG = 2;
	localparam int BIT_EXT_FLAG = 1;
	localparam int BIT_POR_FLAG = 0;
	// timed sequence windows, in clock cycles
	localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
	localparam logic [2:0] SDIS_LIFE_CYC = 3'h3;
	localparam logic [15:0] DELAY_DEFAULT = 16'h0040;
	localparam logic [31:0] APB_ERR_NONE = 32'h0;

	// raw reset sources, all active high
	typedef struct packed {
		logic power_on;
		logic ext_pin_low;
		logic watchdog;
		logic brownout;
	} spg_rst_src_s;

	// gated peripheral clock enables
	typedef struct packed {
		logic two_wire_interface;
		logic timer_two;
		logic timer_zero;
		logic timer_one;
		logic spi;
		logic usart;
		logic adc;
	} spg_clk_en_s;
endpackage

// ---- dv/spg_core_model.sv ----
/*
 processor core model: apb master for register writes and reads, and the
 sleep instruction strobe.
 assumes one clock shared with the controller; pready is sampled each edge.
*/
`timescale 1ns/1ps
module spg_core_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	output logic sleep_instr,
	input wire logic sleep_enter
);
	// idle bus from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		sleep_instr = 1'b0;
	end

	// one transfer; released lines flip so stale values never look valid
	// unlock then set, one write each
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	// one-cycle sleep; caller sets enable just before and clears after
	// enable around sleep
	task sleep_op(output logic seen);
		@(posedge clk);
		sleep_instr <= 1'b1;
		@(posedge clk);
		sleep_instr <= 1'b0;
		#1;
		seen = sleep_enter;
	endtask
endmodule

// ---- dv/spg_ctrl_asserts.sv ----
/*
 concurrent checks on the sleep, clock gating and reset ports.
 assumes binding onto spg_ctrl; single clock domain with sync reset.
*/
`timescale 1ns/1ps
module spg_ctrl_asserts (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic SLEEP_INSTR,
	input wire logic CRYSTAL_CLOCK_SEL,
	input wire logic TIMER_TWO_ASYNC_SELECT,
	input wire logic RESET_PIN_DISABLE_SETTING,
	input wire logic BROWNOUT_ENABLED,
	input wire spg_pkg::spg_rst_src_s RESET_SOURCES,
	input wire spg_pkg::spg_clk_en_s PERIPH_ACCESS,
	input wire logic SLEEP_ENTER,
	input wire logic [2:0] SLEEP_MODE,
	input wire logic BROWNOUT_SLEEP_OFF,
	input wire spg_pkg::spg_clk_en_s CLK_EN,
	input wire spg_pkg::spg_clk_en_s PERIPH_ACCESS_OK,
	input wire logic PORT_RESET,
	input wire logic INTERNAL_RESET,
	input wire logic FETCH_START
);
	import spg_pkg::*;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	property p_sleep_cause;
		$rose(SLEEP_ENTER) |-> $past(SLEEP_INSTR);
	endproperty
	a_sleep_cause: assert property (p_sleep_cause) else $error("sleep entered without instruction");
	property p_standby;
		$rose(SLEEP_ENTER) && SLEEP_MODE[2:1] == 2'b11 |-> $past(CRYSTAL_CLOCK_SEL);
	endproperty
	a_standby: assert property (p_standby) else $error("standby entered without crystal");
	property p_bo_off;
		$rose(BROWNOUT_SLEEP_OFF) |-> $rose(SLEEP_ENTER);
	endproperty
	a_bo_off: assert property (p_bo_off) else $error("detector off outside sleep entry");
	property p_por;
		RESET_SOURCES.power_on || RESET_SOURCES.watchdog |-> PORT_RESET;
	endproperty
	a_por: assert property (p_por) else $error("port reset missing");
	property p_ext;
		RESET_SOURCES.ext_pin_low && !RESET_PIN_DISABLE_SETTING |-> PORT_RESET;
	endproperty
	a_ext: assert property (p_ext) else $error("pin reset missing");
	property p_brown;
		RESET_SOURCES.brownout && BROWNOUT_ENABLED |-> PORT_RESET;
	endproperty
	a_brown: assert property (p_brown) else $error("brown-out reset missing");
	property p_wdog;
		RESET_SOURCES.watchdog |=> INTERNAL_RESET [*4];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog reset not stretched");
	property p_release;
		$fell(INTERNAL_RESET) |-> !$past(PORT_RESET) && !$past(PORT_RESET, 2);
	endproperty
	a_release: assert property (p_release) else $error("reset released too early");
	property p_fetch;
		$fell(INTERNAL_RESET) |-> ##[0:1] FETCH_START ##1 !FETCH_START;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch start missing");
	property p_access;
		PERIPH_ACCESS_OK == (PERIPH_ACCESS & CLK_EN);
	endproperty
	a_access: assert property (p_access) else $error("access passed a stopped clock");
	property p_async;
		TIMER_TWO_ASYNC_SELECT |-> CLK_EN.timer_two;
	endproperty
	a_async: assert property (p_async) else $error("async timer gated");
endmodule

bind spg_ctrl spg_ctrl_asserts i_spg_ctrl_asserts (.REF_CLK(REF_CLK), .RST(RST), .SLEEP_INSTR(SLEEP_INSTR),
	.CRYSTAL_CLOCK_SEL(CRYSTAL_CLOCK_SEL), .TIMER_TWO_ASYNC_SELECT(TIMER_TWO_ASYNC_SELECT),
	.RESET_PIN_DISABLE_SETTING(RESET_PIN_DISABLE_SETTING), .BROWNOUT_ENABLED(BROWNOUT_ENABLED),
	.RESET_SOURCES(RESET_SOURCES), .PERIPH_ACCESS(PERIPH_ACCESS), .SLEEP_ENTER(SLEEP_ENTER),
	.SLEEP_MODE(SLEEP_MODE), .BROWNOUT_SLEEP_OFF(BROWNOUT_SLEEP_OFF), .CLK_EN(CLK_EN),
	.PERIPH_ACCESS_OK(PERIPH_ACCESS_OK), .PORT_RESET(PORT_RESET), .INTERNAL_RESET(INTERNAL_RESET),
	.FETCH_START(FETCH_START));

// ---- dv/sleep_power_gate_reset_ctrl_bench.sv ----
/*
 self-checking bench: register sequences over apb, sleep gating, clock
 gating table and reset source scenarios.
 assumes spg_core_model as bus master and a short rst-time stretch.
*/
`timescale 1ns/1ps
module sleep_power_gate_reset_ctrl_bench;
	import spg_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, sleep_instr, seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic xtal = 1'b0;
	logic t2_async = 1'b0;
	logic pin_off = 1'b0;
	logic bo_en = 1'b0;
	spg_rst_src_s src = '0;
	spg_clk_en_s acc = '1;
	spg_clk_en_s clk_en, acc_ok;
	logic sleep_enter, bo_off, pullup_off, vec_sel, port_rst, int_rst, fetch;
	logic [2:0] mode;
	logic [7:0] pr;
	logic [6:0] ge;
	int n_mismatch = 0;
	int n_compared = 0;

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	spg_ctrl #(.DELAY_CYCLES(16'h0004)) i_spg_ctrl (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SLEEP_INSTR(sleep_instr), .CRYSTAL_CLOCK_SEL(xtal),
		.TIMER_TWO_ASYNC_SELECT(t2_async), .RESET_PIN_DISABLE_SETTING(pin_off),
		.BROWNOUT_ENABLED(bo_en), .RESET_SOURCES(src), .PERIPH_ACCESS(acc), .SLEEP_ENTER(sleep_enter),
		.SLEEP_MODE(mode), .BROWNOUT_SLEEP_OFF(bo_off), .GLOBAL_PULLUP_DISABLE(pullup_off),
		.VECTOR_TABLE_SELECT(vec_sel), .CLK_EN(clk_en), .PERIPH_ACCESS_OK(acc_ok),
		.PORT_RESET(port_rst), .INTERNAL_RESET(int_rst), .FETCH_START(fetch));

	spg_core_model i_spg_core_model (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .sleep_instr(sleep_instr),
		.sleep_enter(sleep_enter));

	task wr(input logic [11:0] a, input logic [31:0] d);
		i_spg_core_model.apb(1'b1, a, d, rd_data);
	endtask

	task rd(input logic [11:0] a);
		i_spg_core_model.apb(1'b0, a, 32'h0, rd_data);
	endtask

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_pin(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask

	// bounded wait for the fetch pulse that ends a reset
	task wait_fetch;
		for (int i = 0; i < 300 && fetch !== 1'b1; i++)
			@(posedge ref_clk);
		chk_pin(fetch, 1'b1);
	endtask

	task wrap_up;
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, far beyond the several hundred cycles of the tests
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		wrap_up;
	end

	// main sequence
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		wait_fetch;
		wr(POWER_REDUCTION_ADDR, 32'hff);
		rd(POWER_REDUCTION_ADDR);
		chk_word(rd_data, 32'hef);
		rd(12'h200);
		chk_word(rd_data, 32'h0);
		chk_pin(pslverr, 1'b0);
		// each gate bit alone, timer two sync then async
		for (int k = 0; k < 16; k++)
		begin
			pr = 8'h01 << (k % 8);
			ge = ~{pr[7], pr[6] & ~k[3], pr[5], pr[3], pr[2], pr[1], pr[0]};
			@(posedge ref_clk);
			t2_async <= k[3];
			wr(POWER_REDUCTION_ADDR, {24'h0, pr});
			@(negedge ref_clk);
			chk_word({25'h0, clk_en}, {25'h0, ge});
			chk_word({25'h0, acc_ok}, {25'h0, ge});
		end
		wr(POWER_REDUCTION_ADDR, 32'h0);
		// unlock then set inside the window, then self-clear
		wr(MCU_CONTROL_ADDR, 32'h60);
		wr(MCU_CONTROL_ADDR, 32'h40);
		rd(MCU_CONTROL_ADDR);
		chk_pin(rd_data[BIT_SDIS], 1'b1);
		repeat (6) @(posedge ref_clk);
		rd(MCU_CONTROL_ADDR);
		chk_pin(rd_data[BIT_SDIS], 1'b0);
		wr(MCU_CONTROL_ADDR, 32'h60);
		repeat (5) @(posedge ref_clk);
		wr(MCU_CONTROL_ADDR, 32'h40);
		rd(MCU_CONTROL_ADDR);
		chk_pin(rd_data[BIT_SDIS], 1'b0);
		wr(SLEEP_CONTROL_ADDR, 32'h0);
		i_spg_core_model.sleep_op(seen);
		chk_pin(seen, 1'b0);
		// every defined mode, with and without crystal
		for (int m = 0; m < 16; m++)
		begin
			if (m[3:1] == 3'h4 || m[3:1] == 3'h5)
				continue;
			xtal <= m[0];
			wr(SLEEP_CONTROL_ADDR, {28'h0, m[3:0] | 4'h1});
			i_spg_core_model.sleep_op(seen);
			chk_pin(seen, (m < 12) || m[0]);
			chk_word({29'h0, mode}, {29'h0, m[3:1]});
			wr(SLEEP_CONTROL_ADDR, {28'h0, m[3:1], 1'b0});
		end
		// sleep in the disable bit's active cycle, then again after self-clear
		wr(SLEEP_CONTROL_ADDR, 32'h1);
		wr(MCU_CONTROL_ADDR, 32'h60);
		wr(MCU_CONTROL_ADDR, 32'h40);
		repeat (2) @(posedge ref_clk);
		i_spg_core_model.sleep_op(seen);
		chk_pin(seen, 1'b1);
		chk_pin(bo_off, 1'b1);
		i_spg_core_model.sleep_op(seen);
		chk_pin(bo_off, 1'b0);
		wr(SLEEP_CONTROL_ADDR, 32'h0);
		// pull-up and vector select, set here and cleared by the next reset
		wr(MCU_CONTROL_ADDR, 32'h02);
		@(negedge ref_clk);
		chk_pin(vec_sel, 1'b0);
		wr(MCU_CONTROL_ADDR, 32'h11);
		wr(MCU_CONTROL_ADDR, 32'h12);
		@(negedge ref_clk);
		chk_pin(pullup_off, 1'b1);
		chk_pin(vec_sel, 1'b1);
		wr(POWER_REDUCTION_ADDR, 32'h01);
		// unqualified sources must not reset
		@(posedge ref_clk);
		pin_off <= 1'b1;
		src <= 4'b0100;
		@(negedge ref_clk);
		chk_pin(port_rst, 1'b0);
		@(posedge ref_clk);
		src <= 4'b0001;
		@(negedge ref_clk);
		chk_pin(port_rst, 1'b0);
		@(posedge ref_clk);
		bo_en <= 1'b1;
		@(negedge ref_clk);
		chk_pin(port_rst, 1'b1);
		@(posedge ref_clk);
		src <= 4'b0000;
		repeat (3) @(negedge ref_clk);
		chk_pin(int_rst, 1'b1);
		wait_fetch;
		rd(POWER_REDUCTION_ADDR);
		chk_word(rd_data, 32'h0);
		chk_pin(pullup_off, 1'b0);
		chk_pin(vec_sel, 1'b0);
		// one-cycle watchdog pulse
		@(posedge ref_clk);
		src <= 4'b0010;
		@(negedge ref_clk);
		chk_pin(port_rst, 1'b1);
		@(posedge ref_clk);
		src <= 4'b0000;
		wait_fetch;
		rd(RESET_STATUS_ADDR);
		chk_pin(rd_data[BIT_WDOG_FLAG], 1'b1);
		wr(RESET_STATUS_ADDR, 32'h0);
		rd(RESET_STATUS_ADDR);
		chk_word(rd_data, 32'h0);
		// enabled pin reset sets only its own cause flag
		@(posedge ref_clk);
		pin_off <= 1'b0;
		src <= 4'b0100;
		@(negedge ref_clk);
		chk_pin(port_rst, 1'b1);
		@(posedge ref_clk);
		src <= 4'b0000;
		wait_fetch;
		rd(RESET_STATUS_ADDR);
		chk_word(rd_data, 32'h2);
		// power-on forces the status to its own flag
		@(posedge ref_clk);
		src <= 4'b1000;
		@(negedge ref_clk);
		chk_pin(port_rst, 1'b1);
		@(posedge ref_clk);
		src <= 4'b0000;
		wait_fetch;
		rd(RESET_STATUS_ADDR);
		chk_word(rd_data, 32'h1);
		wrap_up;
	end
endmodule
